// file: irq_enable_pkg.sv
// Constants, field layout and bus carriers for the peripheral interrupt enable block
package irq_enable_pkg;

    // ****************************************************************
    // Widths
    // ****************************************************************
    localparam int REG_WIDTH  = 8;                    // Register data width
    localparam int ADDR_WIDTH = 8;                    // Byte address width
    localparam int BUS_WIDTH  = 32;                   // Wishbone data width
    localparam int SEL_WIDTH  = 4;                    // Byte select width

    // ****************************************************************
    // Register map (byte addresses)
    // ****************************************************************
    localparam logic [ADDR_WIDTH-1:0] ENABLE_OFS = 8'h00; // Enable register
    localparam logic [ADDR_WIDTH-1:0] FLAG_OFS   = 8'h04; // Sticky flags, write one to clear
    localparam logic [ADDR_WIDTH-1:0] CTRL_OFS   = 8'h08; // Global and master enables
    localparam logic [ADDR_WIDTH-1:0] STATUS_OFS = 8'h0c; // Pending requests, read only

    // ****************************************************************
    // Field positions of the enable and flag registers
    // ****************************************************************
    localparam int BIT_T1_GATE   = 7;                 // Timer-1 gate acquisition
    localparam int BIT_CONVERTER = 6;                 // Converter completion
    localparam int BIT_SER_RX    = 5;                 // Serial receive
    localparam int BIT_SER_TX    = 4;                 // Serial transmit
    localparam int BIT_SYNC_PORT = 3;                 // Synchronous serial port
    localparam int BIT_UNUSED    = 2;                 // Unimplemented
    localparam int BIT_T2_MATCH  = 1;                 // Timer-2 period match
    localparam int BIT_T1_OVF    = 0;                 // Timer-1 overflow

    // Field positions of the control register
    localparam int CTRL_GLOBAL_BIT = 7;               // global_irq_en
    localparam int CTRL_PERIPH_BIT = 6;               // periph_master_en

    // Byte lane that carries the register byte
    localparam int LANE_LOW = 0;

    // ****************************************************************
    // Reset values
    // ****************************************************************
    localparam logic [REG_WIDTH-1:0] ENABLE_RESET = 8'h00;
    localparam logic [REG_WIDTH-1:0] FLAG_RESET   = 8'h00;
    localparam logic                 CTRL_RESET   = 1'h0;
    localparam logic [BUS_WIDTH-1:0] BUS_ZERO     = 32'h0000_0000;

    // ****************************************************************
    // Bus carriers
    // ****************************************************************
    typedef struct packed {
        logic                  cyc;                   // Cycle in progress
        logic                  stb;                   // Strobe
        logic                  we;                    // Write enable
        logic [ADDR_WIDTH-1:0] adr;                   // Byte address
        logic [SEL_WIDTH-1:0]  sel;                   // Byte selects
        logic [BUS_WIDTH-1:0]  dat;                   // Write data
    } wb_req_t;

    typedef struct packed {
        logic                 ack;                    // Acknowledge
        logic [BUS_WIDTH-1:0] dat;                    // Read data
    } wb_rsp_t;

endpackage

// file: irq_source_cell.sv
// One interrupt source: enable bit, sticky flag and gated request
`timescale 1ns/1ps
module irq_source_cell #(
    parameter bit IMPLEMENTED = 1'b1                  // Zero leaves the slot empty
) (
    input  wire logic sys_clk,
    input  wire logic rst,
    input  wire logic ce,
    input  wire logic enWrite,                        // Enable register write strobe
    input  wire logic enData,                         // Bit value being written
    input  wire logic flagClear,                      // Software clear of the flag
    input  wire logic srcEvent,                       // Peripheral event pulse
    output logic      enBit,                          // Stored enable
    output logic      flagBit,                        // Stored flag
    output logic      request                         // Flag passed by the enable
);
    import irq_enable_pkg::*;

    // Enable bit: software writes it, every reset clears it
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            enBit <= CTRL_RESET;
        end else if (ce && enWrite && IMPLEMENTED) begin
            enBit <= enData;
        end
    end

    // Flag: set by the event whatever the enables say; a set beats a clear
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            flagBit <= CTRL_RESET;
        end else if (ce && IMPLEMENTED) begin
            if (srcEvent) begin
                flagBit <= 1'b1;
            end else if (flagClear) begin
                flagBit <= 1'b0;
            end
        end
    end

    // Only an enabled flag leaves the cell
    assign request = IMPLEMENTED & enBit & flagBit;

endmodule

// file: periph_irq_enable.sv
// Peripheral interrupt enable register with Wishbone slave and core request
//
// Our own choices: the Wishbone slave port and the address map.
`timescale 1ns/1ps
module periph_irq_enable #(
    parameter bit HAS_CONVERTER = 1'b1                // Zero on variants without converter
) (
    input  wire logic                    sys_clk,
    input  wire logic                    rst,
    input  wire logic                    ce,
    input  wire irq_enable_pkg::wb_req_t wbReq,
    output irq_enable_pkg::wb_rsp_t      wbRsp,
    input  wire logic [7:0]              srcEvent,
    output logic                         irqToCore
);
    import irq_enable_pkg::*;

    // ****************************************************************
    // Bus decode
    // ****************************************************************

    logic                 ackReg;                     // Acknowledge flop
    logic [BUS_WIDTH-1:0] rdatReg;                    // Read data flop
    logic                 request;                    // New access this cycle
    logic                 wrAccess;                   // Write that commits now
    logic                 laneLow;                    // Low byte lane selected
    logic                 hitEnable;                  // Enable register addressed
    logic                 hitFlag;                    // Flag register addressed
    logic                 hitCtrl;                    // Control register addressed
    logic                 hitStatus;                  // Status register addressed
    logic [REG_WIDTH-1:0] wrByte;                     // Low byte of write data

    // A request is new only while no acknowledge is out, so a held request
    // in the ack cycle does not commit a second time
    assign request  = wbReq.cyc & wbReq.stb & ~ackReg;
    assign wrAccess = request & wbReq.we;
    assign laneLow  = wbReq.sel[LANE_LOW];
    assign wrByte   = wbReq.dat[REG_WIDTH-1:0];

    // Address compare for each mapped register
    assign hitEnable = (wbReq.adr == ENABLE_OFS);
    assign hitFlag   = (wbReq.adr == FLAG_OFS);
    assign hitCtrl   = (wbReq.adr == CTRL_OFS);
    assign hitStatus = (wbReq.adr == STATUS_OFS);

    // ****************************************************************
    // Control register: global and peripheral master enables
    // ****************************************************************

    logic globalEnReg;                                // global_irq_en
    logic periphEnReg;                                // periph_master_en

    // Global enable: software only
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            globalEnReg <= CTRL_RESET;
        end else if (ce && wrAccess && hitCtrl && laneLow) begin
            globalEnReg <= wrByte[CTRL_GLOBAL_BIT];
        end
    end

    // Peripheral master enable: software only
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            periphEnReg <= CTRL_RESET;
        end else if (ce && wrAccess && hitCtrl && laneLow) begin
            periphEnReg <= wrByte[CTRL_PERIPH_BIT];
        end
    end

    // ****************************************************************
    // Source cells
    // ****************************************************************

    logic [REG_WIDTH-1:0] implMask;                   // Which slots exist
    logic [REG_WIDTH-1:0] enBits;                     // peripheral_irq_enable_one
    logic [REG_WIDTH-1:0] flagBits;                   // Sticky flags
    logic [REG_WIDTH-1:0] pendBits;                   // Flags passed by enables
    logic                 enWrite;                    // Enable register write
    logic                 flagWrite;                  // Flag register write

    assign enWrite   = wrAccess & hitEnable & laneLow;
    assign flagWrite = wrAccess & hitFlag & laneLow;

    // Slot map: bit 2 is always empty, bit 6 only with the converter
    always_comb begin
        implMask                = {REG_WIDTH{1'b1}};
        implMask[BIT_UNUSED]    = 1'b0;
        implMask[BIT_CONVERTER] = HAS_CONVERTER;
    end

    // One cell per bit; empty slots keep their flops at reset value, which
    // costs a few idle flops but keeps the map regular
    genvar gi;
    generate
        for (gi = 0; gi < REG_WIDTH; gi++) begin : gSrc
            localparam bit IMPL = (gi != BIT_UNUSED) &&
                                  ((gi != BIT_CONVERTER) || HAS_CONVERTER);
            irq_source_cell #(
                .IMPLEMENTED (IMPL)
            ) uCell (
                .sys_clk   (sys_clk),
                .rst       (rst),
                .ce        (ce),
                .enWrite   (enWrite),
                .enData    (wrByte[gi]),
                .flagClear (flagWrite & wrByte[gi]),
                .srcEvent  (srcEvent[gi]),
                .enBit     (enBits[gi]),
                .flagBit   (flagBits[gi]),
                .request   (pendBits[gi])
            );
        end
    endgenerate

    // ****************************************************************
    // Request to the core
    // ****************************************************************

    logic anyPending;                                 // Some enabled flag is set
    logic irqReg;                                     // Request flop

    assign anyPending = |(pendBits & implMask);

    // Request needs an enabled flag, the master enable and the global enable;
    // registered so the core sees a clean level, one cycle behind the flag
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            irqReg <= CTRL_RESET;
        end else if (ce) begin
            irqReg <= anyPending & periphEnReg & globalEnReg;
        end
    end

    assign irqToCore = irqReg;

    // ****************************************************************
    // Read path
    // ****************************************************************

    logic [BUS_WIDTH-1:0] rdatNext;                   // Read value to capture
    logic [REG_WIDTH-1:0] ctrlByte;                   // Control register image

    // Control image: only the two enable bits are stored
    always_comb begin
        ctrlByte                  = {REG_WIDTH{1'b0}};
        ctrlByte[CTRL_GLOBAL_BIT] = globalEnReg;
        ctrlByte[CTRL_PERIPH_BIT] = periphEnReg;
    end

    // Read mux; unmapped addresses and empty slots read zero
    always_comb begin
        rdatNext = BUS_ZERO;
        if (hitEnable) begin
            rdatNext[REG_WIDTH-1:0] = enBits & implMask;
        end else if (hitFlag) begin
            rdatNext[REG_WIDTH-1:0] = flagBits & implMask;
        end else if (hitCtrl) begin
            rdatNext[REG_WIDTH-1:0] = ctrlByte;
        end else if (hitStatus) begin
            rdatNext[REG_WIDTH-1:0] = pendBits & implMask;
        end else begin
            rdatNext = BUS_ZERO;
        end
    end

    // Acknowledge: one cycle after the request, dropped the cycle after;
    // unmapped addresses are acknowledged too so the master never hangs
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            ackReg <= CTRL_RESET;
        end else if (ce) begin
            ackReg <= request;
        end
    end

    // Read data is captured with the acknowledge and cleared otherwise
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            rdatReg <= BUS_ZERO;
        end else if (ce) begin
            if (request && !wbReq.we) begin
                rdatReg <= rdatNext;
            end else begin
                rdatReg <= BUS_ZERO;
            end
        end
    end

    assign wbRsp.ack = ackReg;
    assign wbRsp.dat = rdatReg;

endmodule

// file: periph_irq_enable_chk.sv
// Bus and request checks for the peripheral interrupt enable block
`timescale 1ns/1ps
module periph_irq_enable_chk #(
    parameter bit HAS_CONVERTER = 1'b1                // Same as the design
) (
    input wire logic                    sys_clk,
    input wire logic                    rst,
    input wire logic                    ce,
    input wire irq_enable_pkg::wb_req_t wbReq,
    input wire irq_enable_pkg::wb_rsp_t wbRsp,
    input wire logic [7:0]              srcEvent,
    input wire logic                    irqToCore
);
    import irq_enable_pkg::*;
    // ************************************************
    // Shadow of enable and control registers
    // ************************************************
    logic [7:0] shadowEn;                             // Expected enable byte
    logic [1:0] shadowCtrl;                           // Global, master enables
    logic       take;                                 // Access accepted here
    logic [7:0] implMask;                             // Bits that hold a value
    assign take = wbReq.cyc && wbReq.stb && !wbRsp.ack && ce;
    assign implMask = (HAS_CONVERTER) ? 8'hfb : 8'hbb;
    // Follow committed writes; a low byte select leaves the byte alone
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            shadowEn <= 8'h00;
            shadowCtrl <= 2'h0;
        end else if (take && wbReq.we && wbReq.sel[0]) begin
            if (wbReq.adr == ENABLE_OFS) begin
                shadowEn <= wbReq.dat[7:0] & implMask;
            end
            if (wbReq.adr == CTRL_OFS) begin
                shadowCtrl <= wbReq.dat[7:6];
            end
        end
    end
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (rst);
    a_ack_after_take: assert property (take |=> wbRsp.ack)
        else $error("ack missing after accepted request");
    a_ack_one_pulse: assert property (wbRsp.ack && ce |=> !wbRsp.ack)
        else $error("ack longer than one cycle");
    a_ack_has_cause: assert property (wbRsp.ack |-> $past(wbReq.cyc && wbReq.stb))
        else $error("ack without request");
    a_enable_read_back: assert property (wbRsp.ack && !wbReq.we && wbReq.adr == ENABLE_OFS
        |-> wbRsp.dat == {24'h0, shadowEn})
        else $error("enable read differs from written value");
    a_unused_bit_zero: assert property (wbRsp.ack && wbReq.adr == ENABLE_OFS
        |-> !wbRsp.dat[BIT_UNUSED])
        else $error("unimplemented bit reads one");
    a_irq_needs_master: assert property (irqToCore |-> $past(shadowCtrl[0]))
        else $error("request without master enable");
    a_irq_needs_global: assert property (irqToCore |-> $past(shadowCtrl[1]))
        else $error("request without global enable");
    a_irq_needs_enable: assert property (irqToCore |-> $past(shadowEn) != 8'h00)
        else $error("request with all enables clear");
    // An event sets its flag at once; one edge later the request follows
    a_event_to_request: assert property (ce && (srcEvent & implMask) != 8'h00 ##1
        ce && ($past(srcEvent) & shadowEn) != 8'h00 && shadowCtrl == 2'h3
        |=> irqToCore)
        else $error("enabled event did not raise the request");
    a_reset_clears_out: assert property (disable iff (1'b0)
        rst && ce |=> !wbRsp.ack && !irqToCore)
        else $error("outputs not cleared by reset");
endmodule

bind periph_irq_enable periph_irq_enable_chk #(.HAS_CONVERTER(HAS_CONVERTER)) i_chk (
    .sys_clk(sys_clk), .rst(rst), .ce(ce), .wbReq(wbReq), .wbRsp(wbRsp),
    .srcEvent(srcEvent), .irqToCore(irqToCore));

// file: periph_irq_enable_tb_top.sv
// Self-checking bench for the peripheral interrupt enable block
`timescale 1ns/1ps
module periph_irq_enable_tb_top;
    import irq_enable_pkg::*;
    logic       sysClk;                               // 200 MHz clock
    logic       rst;                                  // Synchronous reset
    logic       ce;                                   // Clock enable, high except for four edges in one test
    wb_req_t    wbReq;                                // Bus request
    wb_rsp_t    wbRsp;                                // Bus response
    logic [7:0] srcEvent;                             // Peripheral events
    logic       irqToCore;                            // Request to the core
    int         errorCnt;                             // Mismatches
    int         samplesChecked;                       // Comparisons
    int         seed;                                 // Fixed random seed
    logic [31:0] rd;                                  // Last read word
    logic [7:0] en;                                   // Enable pattern
    logic [7:0] ev;                                   // Event pattern
    logic [7:0] ctl;                                  // Control pattern

    periph_irq_enable i_periph_irq_enable (.sys_clk(sysClk), .rst(rst), .ce(ce),
        .wbReq(wbReq), .wbRsp(wbRsp), .srcEvent(srcEvent), .irqToCore(irqToCore));

    // Clock
    initial begin
        sysClk = 1'b0;
        forever #2.5 sysClk = ~sysClk;
    end

    // Counts and verdict, also reached by the watchdog
    task automatic finishTest();
        $display("Comparisons %0d mismatches %0d", samplesChecked, errorCnt);
        if (errorCnt == 0 && samplesChecked > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    // Whole read word: upper bytes must read zero as well
    task automatic chk8(input logic [31:0] got, input logic [7:0] exp);
        samplesChecked++;
        if (got !== {24'h0, exp}) begin
            errorCnt++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, {24'h0, exp});
        end
    endtask

    task automatic chk1(input logic got, input logic exp);
        samplesChecked++;
        if (got !== exp) begin
            errorCnt++;
            $display("BAD t=%0t irq got=%h exp=%h", $time, got, exp);
        end
    endtask

    // One classic cycle; no fixed latency assumed, only the watchdog ends a hang
    task automatic wbAccess(input logic w, input logic [7:0] a, input logic [7:0] d,
                            input logic [3:0] s);
        @(posedge sysClk);
        wbReq <= '{cyc: 1'b1, stb: 1'b1, we: w, adr: a, sel: s, dat: {24'h0, d}};
        do begin
            @(posedge sysClk);
        end while (wbRsp.ack !== 1'b1);
        rd = wbRsp.dat;
        wbReq <= '0;
    endtask

    task automatic rdChk(input logic [7:0] a, input logic [7:0] exp);
        wbAccess(1'b0, a, 8'h00, 4'h0);
        chk8(rd, exp);
    endtask

    // One-cycle event pulse, then two edges for flag and request to settle
    task automatic fire(input logic [7:0] e);
        @(posedge sysClk);
        srcEvent <= e;
        @(posedge sysClk);
        srcEvent <= 8'h00;
        repeat (2) @(posedge sysClk);
    endtask

    // Request only if a flagged source is enabled and both master bits are set
    function automatic logic expIrq(logic [7:0] e, logic [7:0] f, logic [7:0] c);
        return (|(e & f & 8'hfb)) & c[7] & c[6];
    endfunction

    initial begin
        seed = 32'h51656ca9;
        errorCnt = 0;
        samplesChecked = 0;
        rst = 1'b1;
        ce = 1'b1;
        wbReq = '0;
        srcEvent = 8'h00;
        repeat (10) @(posedge sysClk);
        rst <= 1'b0;
        rdChk(ENABLE_OFS, 8'h00);
        // Corner and random enable patterns; bit 2 never sticks
        for (int i = 0; i < 20; i++) begin
            en = (i == 0) ? 8'hff : (i == 1) ? 8'h04 : 8'($random(seed));
            wbAccess(1'b1, ENABLE_OFS, en, 4'h1);
            rdChk(ENABLE_OFS, en & 8'hfb);
        end
        // Lane off and unmapped writes leave the register alone
        wbAccess(1'b1, ENABLE_OFS, ~en, 4'h0);
        wbAccess(1'b1, 8'h10, 8'hff, 4'h1);
        rdChk(8'h10, 8'h00);
        rdChk(ENABLE_OFS, en & 8'hfb);
        // Gating by enables and both master bits; the first four walk the master bits
        for (int i = 0; i < 24; i++) begin
            ctl = (i < 4) ? 8'(i << 6) : 8'($random(seed));
            en = (i < 4) ? 8'hff : 8'($random(seed));
            ev = (i < 4) ? 8'hff : 8'($random(seed));
            wbAccess(1'b1, FLAG_OFS, 8'hff, 4'h1);
            wbAccess(1'b1, CTRL_OFS, ctl, 4'h1);
            wbAccess(1'b1, ENABLE_OFS, en, 4'h1);
            fire(ev);
            chk1(irqToCore, expIrq(en, ev, ctl));
            rdChk(FLAG_OFS, ev & 8'hfb);
            rdChk(STATUS_OFS, en & ev & 8'hfb);
            rdChk(CTRL_OFS, ctl & 8'hc0);
            // Write one to clear: only the flags under the pattern drop
            wbAccess(1'b1, FLAG_OFS, en, 4'h1);
            rdChk(FLAG_OFS, ev & ~en & 8'hfb);
        end
        // Event on the very edge that commits a clear: the set must win
        fork
            wbAccess(1'b1, FLAG_OFS, 8'hff, 4'h1);
            begin
                @(posedge sysClk);
                srcEvent <= 8'hff;
                @(posedge sysClk);
                srcEvent <= 8'h00;
            end
        join
        rdChk(FLAG_OFS, 8'hfb);
        // Clock enable low: events are ignored and a held write waits
        wbAccess(1'b1, FLAG_OFS, 8'hff, 4'h1);
        fork
            wbAccess(1'b1, ENABLE_OFS, 8'h5e, 4'h1);
            begin
                ce <= 1'b0;
                srcEvent <= 8'hff;
                repeat (4) @(posedge sysClk);
                ce <= 1'b1;
                srcEvent <= 8'h00;
            end
        join
        rdChk(FLAG_OFS, 8'h00);
        rdChk(ENABLE_OFS, 8'h5e & 8'hfb);
        // Raise the request so the reset below has something to clear
        wbAccess(1'b1, CTRL_OFS, 8'hc0, 4'h1);
        fire(8'hff);
        chk1(irqToCore, 1'b1);
        // Reset in mid-run clears enables, flags, control and the request
        @(posedge sysClk);
        rst <= 1'b1;
        @(posedge sysClk);
        rst <= 1'b0;
        rdChk(ENABLE_OFS, 8'h00);
        rdChk(FLAG_OFS, 8'h00);
        rdChk(CTRL_OFS, 8'h00);
        chk1(irqToCore, 1'b0);
        finishTest();
    end

    // Watchdog well past the expected run length
    initial begin
        repeat (20000) @(posedge sysClk);
        errorCnt++;
        finishTest();
    end
endmodule
